// >>> hdl/dpi_pkg.sv
/*
  Shared constants and types for the dual-port interleaving DAC input section.
  Assumes a single system clock i_mclk at 20 MHz and an active-low async reset.
*/
package dpi_pkg;
  localparam int unsigned DATA_W       = 10;
  localparam int unsigned CODE_MAX     = 1023;
  localparam int unsigned CODE_SPAN    = 1024;
  localparam int unsigned CUR_W        = 20;
  localparam int unsigned FS_CURRENT_W = 10;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PRESCALE_W   = 4;
  localparam logic        HALF_CLK_RESET_VAL = 1'b1;
  localparam logic [9:0]  CODE_RESET_VAL     = 10'h000;
  localparam logic [19:0] CUR_RESET_VAL      = 20'h00000;
  localparam logic [3:0]  PRESCALE_RESET_VAL = 4'h1;
  localparam logic [1:0]  SEL_PRESCALE_RANGE_SELECT_HI = 2'h0;
  localparam logic [1:0]  SEL_PRESCALE_DIV2 = 2'h1;
  localparam logic [1:0]  SEL_PRESCALE_DIV4 = 2'h2;
  localparam logic [1:0]  SEL_PRESCALE_DIV8 = 2'h3;
  localparam int unsigned FIFO_DEPTH = 2;

  typedef enum logic [2:0] {
    DPI_MODE_INTERLEAVE = 3'b001,
    DPI_MODE_PORT1      = 3'b010,
    DPI_MODE_PORT2      = 3'b100
  } dpi_mode_e;

  typedef enum logic [2:0] {
    DPI_PH_FIRST  = 3'b001,
    DPI_PH_SECOND = 3'b010,
    DPI_PH_IDLE   = 3'b100
  } dpi_phase_e;
endpackage : dpi_pkg

// >>> hdl/dpi_link_if.sv
/*
  Link between the data source and the DAC input section.
  Assumes both ends share i_mclk; the bench ties the clock to it.
*/
interface dpi_link_if
  import dpi_pkg::*;
  (input wire logic i_mclk);
  logic [DATA_W-1:0] port1_data;
  logic [DATA_W-1:0] port2_data;
  logic              data_valid;
  logic              data_ready;
  logic              range_select_lo;
  logic              range_select_hi;
  logic              multiplier_enable_supply;
  logic              align_reset;
  logic              lock_or_half_clock_out;

  modport dac (
    input  port1_data, port2_data, data_valid, range_select_lo, range_select_hi,
    input  multiplier_enable_supply, align_reset,
    output data_ready, lock_or_half_clock_out
  );
  modport src (
    output port1_data, port2_data, data_valid, range_select_lo, range_select_hi,
    output multiplier_enable_supply, align_reset,
    input  data_ready, lock_or_half_clock_out
  );
endinterface : dpi_link_if

// >>> hdl/dpi_source.sv
/*
  Data source end: feeds word pairs from the user onto both ports.
  Assumes the DAC end answers with data_ready and echoes its 1x clock on the lock pin in bypass.
*/
module dpi_source
  import dpi_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire logic [9:0]  i_word1,
  input  wire logic [9:0]  i_word2,
  input  wire logic        i_word_valid,
  input  wire logic        i_multiplier_on,
  input  wire logic [1:0]  i_range_select,
  input  wire logic        i_align_req,
  output logic             o_word_ready,
  output logic             o_locked,
  dpi_link_if.src          link
);
  typedef struct packed {
    logic [9:0] p1;
    logic [9:0] p2;
    logic       vld;
    logic       mul;
    logic [1:0] sel;
    logic       rst;
    logic       lock;
  } dpi_src_s;

  dpi_src_s st_ff;
  dpi_src_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      // Words move only when the source holds nothing or the DAC end accepts, so nothing is dropped on a stall.
      if (!st_ff.vld || link.data_ready) begin
        nxt_st.vld = i_word_valid;
        if (i_word_valid) begin
          nxt_st.p1 = i_word1;
          nxt_st.p2 = i_word2;
        end
      end
      nxt_st.mul  = i_multiplier_on;
      nxt_st.sel  = i_range_select;
      nxt_st.rst  = i_align_req & ~i_multiplier_on;
      nxt_st.lock = link.lock_or_half_clock_out;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.port1_data               = st_ff.p1;
  assign link.port2_data               = st_ff.p2;
  assign link.data_valid               = st_ff.vld;
  assign link.multiplier_enable_supply = st_ff.mul;
  assign link.range_select_lo          = st_ff.sel[0];
  assign link.range_select_hi          = st_ff.sel[1];
  assign link.align_reset              = st_ff.rst;
  assign o_word_ready                  = !st_ff.vld || link.data_ready;
  assign o_locked                      = st_ff.lock;
endmodule : dpi_source

// >>> hdl/dpi_dac.sv
/*
  DAC end: input latches, two-entry buffer, port mux, DAC latch and current model.
  Assumes i_mclk is the 2x update clock; the source holds data until data_ready.
*/
// Notes on behaviour
// - multiplier on: both ports latched each input cycle.
// - same edge: previous port-two value goes out.
// - half cycle later: port-one value goes out.
// - update instants fixed by internal 2x clock.
// - bypass: source clock runs at update rate.
// - bypass: range selects choose the mux mode.
// - interleaved bypass: 2x clock divided to 1x.
// - bypass: 1x clock echoed on lock output.
// - source changes data on 1x rising edge; here on any edge where it holds nothing or sees data_ready.
// - reset release forces 1x clock high.
// - first edge drives low, second loads latches.
// - edge after release starts the division.
// - single-port mode loads only selected port.
// - single-port: DAC latch takes word next edge; here at the next 1x rise, two edges on.
// - all-ones code: full true, zero complement.
// - currents are code and 1023 minus code.
// - multiplier on: reset ignored, lock reads one.
// - multiplier on: selects set prescale 1,2,4,8.
// - ports are straight binary, msb highest.
module dpi_dac
  import dpi_pkg::*;
#(
  parameter logic [11:0] MODE_MAP = {3'd2, 3'd1, 3'd0, 3'd0}, // sel3..sel0
  parameter int unsigned DEPTH    = FIFO_DEPTH
)(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire logic [9:0]  i_full_scale_current,
  output logic [9:0]       o_dac_code,
  output logic [19:0]      o_true_current_out,
  output logic [19:0]      o_complement_current_out,
  output logic [3:0]       o_prescale,
  output logic [2:0]       o_mode,
  dpi_link_if.dac          link
);
  typedef struct packed {
    logic [1:0][19:0] buf_d;
    logic [1:0]       buf_cnt;
    logic             wr_ptr;
    logic             rd_ptr;
    logic             half_clk;
    logic [9:0]       latch1;
    logic [9:0]       latch2;
    logic             latched;
    logic [9:0]       dac_latch;
    logic [9:0]       code;
    logic [19:0]      cur_a;
    logic [19:0]      cur_b;
    logic [3:0]       prescale;
    logic [2:0]       mode;
    logic             ready;
    logic             lock;
  } dpi_dac_s;

  dpi_dac_s  st_ff;
  dpi_dac_s  nxt_st;
  logic [1:0] sel;
  dpi_mode_e  mode_now;
  logic       rise_1x;
  logic       take;
  logic       pop;
  logic [19:0] head;
  logic        align_hold;
  logic        load1;
  logic        load2;
  logic        dac_upd;
  logic [9:0]  dac_src;
  logic [19:0] cur_a_nx;
  logic [19:0] cur_b_nx;
  logic [3:0]  prescale_nx;
  dpi_mode_e   mode_nx;

  assign sel  = {link.range_select_hi, link.range_select_lo};
  assign head = st_ff.buf_d[st_ff.rd_ptr];
  assign take = link.data_valid && st_ff.ready;

  always_comb begin
    case (MODE_MAP[sel*3 +: 2])
      2'd1:    mode_now = DPI_MODE_PORT1;
      2'd2:    mode_now = DPI_MODE_PORT2;
      default: mode_now = DPI_MODE_INTERLEAVE;
    endcase
  end

  // Align holds the 1x clock high unless multiplying; otherwise it toggles on every 2x edge.
  assign align_hold = !link.multiplier_enable_supply && link.align_reset;
  assign rise_1x    = !align_hold && !st_ff.half_clk;
  assign pop        = rise_1x && (st_ff.buf_cnt != 2'd0);
  assign mode_nx    = link.multiplier_enable_supply ? DPI_MODE_INTERLEAVE : mode_now;

  // Prescale follows the selects; it only means something while multiplying.
  always_comb begin
    case (sel)
      SEL_PRESCALE_RANGE_SELECT_HI: prescale_nx = 4'h1;
      SEL_PRESCALE_DIV2: prescale_nx = 4'h2;
      SEL_PRESCALE_DIV4: prescale_nx = 4'h4;
      SEL_PRESCALE_DIV8: prescale_nx = 4'h8;
      default:           prescale_nx = PRESCALE_RESET_VAL;
    endcase
  end

  // Input latch enables: both ports when interleaving, one port otherwise.
  always_comb begin
    load1 = 1'b0;
    load2 = 1'b0;
    if (pop) begin
      case (mode_nx)
        DPI_MODE_PORT1: begin
          load1 = 1'b1;
        end
        DPI_MODE_PORT2: begin
          load2 = 1'b1;
        end
        default: begin
          load1 = 1'b1;
          load2 = 1'b1;
        end
      endcase
    end
  end

  // DAC latch source: port two on the 1x rise (port one in port-one mode), port one half a period later when interleaving.
  always_comb begin
    dac_upd = 1'b0;
    dac_src = st_ff.latch2;
    if (st_ff.latched) begin
      if (rise_1x) begin
        dac_upd = 1'b1;
        case (st_ff.mode)
          DPI_MODE_PORT1: dac_src = st_ff.latch1;
          default:        dac_src = st_ff.latch2;
        endcase
      end else if (st_ff.mode == DPI_MODE_INTERLEAVE) begin
        dac_upd = 1'b1;
        dac_src = st_ff.latch1;
      end
    end
  end

  // Currents scaled by 1024: true = code*fs, complement = (1023-code)*fs.
  assign cur_a_nx = 20'(st_ff.dac_latch) * 20'(i_full_scale_current);
  assign cur_b_nx = 20'(10'(CODE_MAX) - st_ff.dac_latch) * 20'(i_full_scale_current);

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.prescale = prescale_nx;
      nxt_st.mode     = mode_nx;
      // Internal 1x clock: a divide-by-two of i_mclk, so phases ignore duty cycle.
      nxt_st.half_clk = align_hold ? HALF_CLK_RESET_VAL : ~st_ff.half_clk;
      // Lock pin: echo of 1x clock in bypass, steady one when multiplying.
      nxt_st.lock = link.multiplier_enable_supply ? 1'b1 : nxt_st.half_clk;
      if (pop) begin
        nxt_st.latched = 1'b1;
      end
      // Ports are straight binary with bit 9 as msb.
      if (load1) begin
        nxt_st.latch1 = head[9:0];
      end
      if (load2) begin
        nxt_st.latch2 = head[19:10];
      end
      if (dac_upd) begin
        nxt_st.dac_latch = dac_src;
      end
      // Two-entry buffer absorbs a word while the latch phase is busy.
      if (take) begin
        nxt_st.buf_d[st_ff.wr_ptr] = {link.port2_data, link.port1_data};
        nxt_st.wr_ptr = ~st_ff.wr_ptr;
      end
      if (pop) begin
        nxt_st.rd_ptr = ~st_ff.rd_ptr;
      end
      nxt_st.buf_cnt = st_ff.buf_cnt + {1'b0, take} - {1'b0, pop};
      nxt_st.ready   = (nxt_st.buf_cnt < 2'(DEPTH));
      // Output stage: one register after the DAC latch.
      nxt_st.code  = st_ff.dac_latch;
      nxt_st.cur_a = cur_a_nx;
      nxt_st.cur_b = cur_b_nx;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff          <= '0;
      st_ff.half_clk <= HALF_CLK_RESET_VAL;
      st_ff.ready    <= 1'b1;
      st_ff.lock     <= 1'b1;
      st_ff.prescale <= PRESCALE_RESET_VAL;
      st_ff.mode     <= DPI_MODE_INTERLEAVE;
      st_ff.cur_b    <= CUR_RESET_VAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.data_ready             = st_ff.ready;
  assign link.lock_or_half_clock_out = st_ff.lock;
  assign o_dac_code                  = st_ff.code;
  assign o_true_current_out          = st_ff.cur_a;
  assign o_complement_current_out    = st_ff.cur_b;
  assign o_prescale                  = st_ff.prescale;
  assign o_mode                      = st_ff.mode;
endmodule : dpi_dac

// >>> bench/dpi_link_props.sv
/*
  Concurrent checks on the link between the data source and the DAC input section.
  Assumes it sits beside the one link that joins both design ends, on i_mclk.
*/
module dpi_link_props (
  input wire logic       i_mclk,
  input wire logic       i_reset_n,
  input wire logic       data_valid,
  input wire logic       data_ready,
  input wire logic [9:0] port1_data,
  input wire logic [9:0] port2_data,
  input wire logic       multiplier_enable_supply,
  input wire logic       align_reset,
  input wire logic       lock_or_half_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic byp;
  assign byp = !multiplier_enable_supply && !align_reset;

  chk_lock_mult:
    assert property (multiplier_enable_supply && $past(multiplier_enable_supply)
      |-> lock_or_half_clock_out) else $error("lock low in multiplier mode");
  chk_align_high:
    assert property (align_reset && !multiplier_enable_supply |=> lock_or_half_clock_out)
      else $error("half clock not held high by align");
  chk_align_seq:
    assert property (byp && $past(!multiplier_enable_supply) && $fell(align_reset)
      |=> !lock_or_half_clock_out ##1 lock_or_half_clock_out) else $error("align order");
  chk_half_toggle:
    assert property (byp && $past(byp) |=> lock_or_half_clock_out != $past(lock_or_half_clock_out))
      else $error("half clock did not toggle");
  chk_ready_back:
    assert property (!data_ready |-> ##[1:4] data_ready) else $error("buffer never drained");
  chk_ready_cause:
    assert property ($fell(data_ready) |-> $past(data_valid)) else $error("ready fell unasked");
  chk_valid_hold:
    assert property (data_valid && !data_ready |=> data_valid) else $error("valid dropped");
  chk_data_stable:
    assert property (data_valid && !data_ready |=> $stable(port1_data) && $stable(port2_data))
      else $error("data changed while refused");
endmodule : dpi_link_props

// >>> bench/dual_port_dac_input_interleaver_test.sv
/*
  Self-checking bench: source and DAC ends joined by one link, codes checked in order.
  Assumes a 20 MHz clock; each test resets the pair so the output stream starts clean.
*/
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module dual_port_dac_input_interleaver_test;
  import dpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [9:0]  i_word1 = 10'h000;
  logic [9:0]  i_word2 = 10'h000;
  logic        i_word_valid = 1'b0;
  logic        i_multiplier_on = 1'b0;
  logic [1:0]  i_range_select = 2'h0;
  logic        i_align_req = 1'b0;
  logic [9:0]  fs = 10'h000;
  logic        o_word_ready;
  logic [9:0]  o_dac_code;
  logic [19:0] o_tc;
  logic [19:0] o_cc;
  logic [3:0]  o_prescale;
  logic [2:0]  o_mode;
  logic [9:0]  last_code;
  logic [9:0]  q[$];
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;

  always #25 i_mclk = ~i_mclk;
  dpi_link_if link (.i_mclk(i_mclk));
  dpi_source dpi_source_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_word1(i_word1), .i_word2(i_word2), .i_word_valid(i_word_valid),
    .i_multiplier_on(i_multiplier_on), .i_range_select(i_range_select),
    .i_align_req(i_align_req), .o_word_ready(o_word_ready), .o_locked(), .link(link));
  dpi_dac dpi_dac_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_full_scale_current(fs), .o_dac_code(o_dac_code), .o_true_current_out(o_tc),
    .o_complement_current_out(o_cc), .o_prescale(o_prescale), .o_mode(o_mode), .link(link));
  dpi_link_props dpi_link_props_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .data_valid(link.data_valid), .data_ready(link.data_ready),
    .port1_data(link.port1_data), .port2_data(link.port2_data),
    .multiplier_enable_supply(link.multiplier_enable_supply),
    .align_reset(link.align_reset), .lock_or_half_clock_out(link.lock_or_half_clock_out));

  // Words are nonzero and differ from the last one sent, so every code shows as a change.
  function automatic logic [9:0] nw(input logic [9:0] p);
    logic [9:0] w;
    w = 10'($urandom % 1023 + 1);
    if (w == p) w = (p == 10'h3ff) ? 10'h001 : p + 10'h001;
    return w;
  endfunction : nw

  task automatic results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset_n && o_dac_code !== last_code) begin
      last_code = o_dac_code;
      if (q.size() > 0) begin
        `CHK("code", q[0], o_dac_code)
        `CHK("true", 20'(q[0]) * 20'(fs), o_tc)
        `CHK("compl", (20'h003ff - 20'(q[0])) * 20'(fs), o_cc)
        void'(q.pop_front());
      end
    end
  end

  task automatic run_test(input logic m, input logic [1:0] s);
    logic [9:0] a;
    logic [9:0] b;
    logic [9:0] lo;
    int         kind;
    lo = 10'h000;
    kind = m ? 0 : (s == 2'h2 ? 1 : (s == 2'h3 ? 2 : 0));
    #1 i_reset_n = 1'b0;
    i_multiplier_on = m;
    i_range_select = s;
    fs = 10'($urandom % 1023 + 1);
    q.delete();
    last_code = 10'h000;
    repeat (2) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    repeat (4) @(posedge i_mclk);
    if (m) `CHK("prescale", 4'h1 << s, o_prescale)
    else `CHK("mode", 3'b001 << kind, o_mode)
    for (int k = 0; k < 30; k++) begin
      a = (k == 0) ? 10'h3ff : nw(lo);
      b = nw(a);
      #1 i_word1 = (kind == 2) ? b : a;
      i_word2 = (kind == 2) ? a : b;
      i_word_valid = 1'b1;
      // Ready is registered, so its value just after an edge is what the next edge sees.
      while (o_word_ready !== 1'b1) begin
        @(posedge i_mclk);
        #1;
      end
      @(posedge i_mclk);
      q.push_back(a);
      if (kind == 0) q.push_back(b);
      lo = (kind == 0) ? b : a;
    end
    #1 i_word_valid = 1'b0;
    repeat (14) @(posedge i_mclk);
    `CHK("left", 0, q.size())
    #1 i_align_req = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1 i_align_req = 1'b0;
    repeat (5) @(posedge i_mclk);
    $display("test mult %0d sel %0d done", m, s);
  endtask : run_test

  initial begin
    void'($urandom(25394));
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) run_test(1'(m), 2'(s));
    end
    results();
  end
endmodule : dual_port_dac_input_interleaver_test
